// ### shared/lcs_pkg.sv
// Constants, register map, states and carrier types of the charge sequencer.
// Assumes a 10 MHz APB clock and analog comparators feeding the pin inputs.
// How it works
// RULE1: Battery below the precharge threshold selects precharge at one tenth current.
// RULE2: Floating program pin selects the default 2.8 V precharge threshold.
// RULE3: Battery above threshold at charge start skips precharge, enters fast charge.
// RULE4: Reaching the precharge threshold moves to fast charge at full current.
// RULE5: Nearing 4.1 V or 4.2 V regulation enters constant-voltage phase.
// RULE6: From done, battery below regulation minus 150 mV restarts charging.
// RULE7: The maximum charge timer starts when fast charge begins.
// RULE8: Maximum charge time expiring before end-of-charge raises a fault.
// RULE9: Precharge safety timer of one eighth; expiry while low faults, stops.
// RULE10: End current detected waits max time over 220 before signalling done.
// RULE11: Program pin above 0.8 V ends charging at the end current.
// RULE12: Program pin below 0.8 V keeps charging, flags end as fault, stops on timeout.
// RULE13: Program pin below 0.8 V during precharge forces the default threshold.
// RULE14: Program pin falling through 0.5 V resets the charge timers.
// RULE15: Status pins: charging on/off, done off/on, standby off/off, fault on/on.
// RULE16: Timers count a fixed timebase tick up to a programmable terminal count.
// RULE17: After timeout, charging stays off and fault shown until timer reset or disable.
package lcs_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_TMAX     = 8'h04;
    localparam logic [7:0] OFS_PRESCALE = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0C;
    localparam logic [7:0] OFS_INT_STAT = 8'h10;
    localparam logic [7:0] OFS_INT_MASK = 8'h14;

    // CTRL fields
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_VREG_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;

    // STATUS fields
    localparam int STS_STATE_LSB = 0;
    localparam int STS_END_BIT   = 3;
    localparam int STS_A_BIT     = 4;
    localparam int STS_B_BIT     = 5;
    localparam int STS_DEF_BIT   = 6;

    // Interrupt bits
    localparam int IRQ_W    = 4;
    localparam int IRQ_FAST = 0;
    localparam int IRQ_DONE = 1;
    localparam int IRQ_TMO  = 2;
    localparam int IRQ_END  = 3;
    localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

    // Timer widths and timebase
    localparam int TW = 24;
    localparam int PW = 16;
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned TICK_PERIOD_NS = 1_000_000;
    localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned TMAX_TICKS_DEF = 10_800_000;
    localparam int PRE_SHIFT = 3;      // One eighth of the charge time
    localparam int END_DIV   = 220;    // Deglitch divisor

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_PRE   = 3'b001,
        ST_FAST  = 3'b010,
        ST_CV    = 3'b011,
        ST_DONE  = 3'b100,
        ST_FAULT = 3'b101
    } lcs_state_e;

    // Comparator results from the analog charge path
    typedef struct packed {
        logic below_precharge_voltage_threshold;
        logic below_default_precharge_threshold;
        logic precharge_program_pin_floating;
        logic precharge_program_pin_hi;      // Above 0.8 V
        logic precharge_program_pin_mid;     // Above 0.5 V
        logic near_regulation_voltage;
        logic below_recharge_voltage_threshold;
        logic at_end_of_charge_current_threshold;
    } lcs_cmp_s;

    // Drive requests to the analog charge path
    typedef struct packed {
        logic charge_enable;
        logic precharge_current_sel;   // Low precharge current
        logic fast_charge_current;     // Full constant current
        logic cv_mode;
        logic regulation_voltage_sel;  // 1: 4.2 V, 0: 4.1 V
        logic use_default_threshold;
    } lcs_drive_s;

endpackage : lcs_pkg

// ### src/lcs_tick_counter.sv
// Timebase tick counter with clear, run and terminal count.
// Assumes tick is a one-cycle pulse on pclk and limit is at least one.
`timescale 1ns/1ps
module lcs_tick_counter #(
    parameter int W = 24
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         clear,
    input  wire logic         run,
    input  wire logic         tick,
    input  wire logic [W-1:0] limit,
    output logic              expired
);
    logic [W-1:0] cnt_q;

    // RULE16 count timebase ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (clear) begin
            cnt_q <= '0;
        end else if (run && tick && !expired) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Saturates at the limit so expiry stays visible while run is high, until cleared
    assign expired = run && (cnt_q >= limit);

    // Run may drop right after expiry as the phase moves on, so check the count holds
    AST_CNT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        expired && run && !clear |=> $stable(cnt_q)) else $error("Counter left saturation"); // RULE16

endmodule : lcs_tick_counter

// ### src/lcs_charge_seq.sv
// Charge sequencer: phase state machine, safety timers and APB registers.
// Assumes comparator inputs are asynchronous levels and APB runs on pclk.
`timescale 1ns/1ps
module lcs_charge_seq
    import lcs_pkg::*;
#(
    parameter int unsigned PRESCALE_DEF = TICK_CYCLES,
    parameter int unsigned TMAX_DEF     = TMAX_TICKS_DEF
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire lcs_cmp_s    cmp_i,
    output lcs_drive_s       drive_o,
    output logic             status_out_a_o,
    output logic             status_out_a_oe,
    output logic             status_out_b_o,
    output logic             status_out_b_oe,
    output logic             irq
);
    lcs_cmp_s          sync1_q;
    lcs_cmp_s          cmp;
    logic              mid_prev_q;
    logic [1:0]        ctrl_q;
    logic [TW-1:0]     tmax_q;
    logic [PW-1:0]     prescale_q;
    logic [PW-1:0]     presc_cnt_q;
    logic              tick;
    logic [IRQ_W-1:0]  int_stat_q;
    logic [IRQ_W-1:0]  int_mask_q;
    logic [IRQ_W-1:0]  events;
    lcs_state_e        state_q;
    lcs_state_e        state_d;
    logic              end_flag_q;
    logic              end_set;
    logic              enable;
    logic              use_default;
    logic              vbat_low;
    logic              rst_edge;
    logic              chg_exp;
    logic              pre_exp;
    logic              deg_exp;
    logic [TW-1:0]     pre_lim;
    logic [TW-1:0]     end_lim;
    logic              wr_en;
    logic              rd_setup;
    logic              addr_ok;
    logic              st_on_a;
    logic              st_on_b;

    // Two-stage synchroniser; only the second stage is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            cmp     <= '0;
        end else begin
            sync1_q <= cmp_i;
            cmp     <= sync1_q;
        end
    end

    // RULE14 falling edge through 0.5 V
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mid_prev_q <= 1'b0;
        end else begin
            mid_prev_q <= cmp.precharge_program_pin_mid;
        end
    end
    assign rst_edge = mid_prev_q && !cmp.precharge_program_pin_mid;

    assign enable = ctrl_q[CTRL_EN_BIT];

    // RULE2 floating pin takes the default threshold
    // RULE13 low pin also forces the default threshold
    assign use_default = cmp.precharge_program_pin_floating || !cmp.precharge_program_pin_hi;
    assign vbat_low    = use_default ? cmp.below_default_precharge_threshold
                                     : cmp.below_precharge_voltage_threshold;

    // RULE16 timebase tick from the prescaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_cnt_q <= '0;
        end else if (tick) begin
            presc_cnt_q <= '0;
        end else begin
            presc_cnt_q <= presc_cnt_q + 1'b1;
        end
    end
    assign tick = (presc_cnt_q >= prescale_q - 1'b1) || (prescale_q == '0);

    // RULE9 precharge limit is one eighth; never below one tick
    assign pre_lim = (tmax_q[TW-1:PRE_SHIFT] == '0) ? TW'(1)
                                                    : {{PRE_SHIFT{1'b0}}, tmax_q[TW-1:PRE_SHIFT]};
    // RULE10 deglitch limit is the charge time over 220
    assign end_lim = (tmax_q < TW'(END_DIV)) ? TW'(1) : TW'(tmax_q / TW'(END_DIV));

    // RULE7 charge timer runs from fast charge onward
    lcs_tick_counter #(.W(TW)) u_chg_tmr (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (rst_edge || !(state_q == ST_FAST || state_q == ST_CV)),
        .run     (state_q == ST_FAST || state_q == ST_CV),
        .tick    (tick),
        .limit   (tmax_q),
        .expired (chg_exp)
    );

    // RULE9 precharge safety timer
    lcs_tick_counter #(.W(TW)) u_pre_tmr (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (rst_edge || state_q != ST_PRE),
        .run     (state_q == ST_PRE),
        .tick    (tick),
        .limit   (pre_lim),
        .expired (pre_exp)
    );

    // RULE10 end current must persist for the deglitch time
    lcs_tick_counter #(.W(TW)) u_deg_tmr (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (!(state_q == ST_CV && cmp.at_end_of_charge_current_threshold)),
        .run     (state_q == ST_CV && cmp.at_end_of_charge_current_threshold),
        .tick    (tick),
        .limit   (end_lim),
        .expired (deg_exp)
    );

    // Phase sequencing; timeouts yield to a timer reset edge in the same cycle
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                // RULE1 RULE3 start decision
                if (enable) begin
                    state_d = vbat_low ? ST_PRE : ST_FAST;
                end
            end
            ST_PRE: begin
                // RULE4 threshold reached
                if (!vbat_low) begin
                    state_d = ST_FAST;
                // RULE9 precharge timeout
                end else if (pre_exp && !rst_edge) begin
                    state_d = ST_FAULT;
                end
            end
            ST_FAST: begin
                // RULE8 charge timeout
                if (chg_exp && !rst_edge) begin
                    state_d = ST_FAULT;
                // RULE5 regulation phase
                end else if (cmp.near_regulation_voltage) begin
                    state_d = ST_CV;
                end
            end
            ST_CV: begin
                // RULE8 RULE12 timeout ends charging
                if (chg_exp && !rst_edge) begin
                    state_d = ST_FAULT;
                // RULE11 terminate at end current
                end else if (deg_exp && cmp.precharge_program_pin_hi) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                // RULE6 recharge below threshold
                if (cmp.below_recharge_voltage_threshold) begin
                    state_d = vbat_low ? ST_PRE : ST_FAST;
                end
            end
            ST_FAULT: begin
                // RULE17 held until timer reset
                if (rst_edge) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (!enable) begin
            state_d = ST_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // RULE12 end reported as fault while charging continues
    assign end_set = state_q == ST_CV && deg_exp && !cmp.precharge_program_pin_hi && !end_flag_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            end_flag_q <= 1'b0;
        end else if (state_d != ST_CV) begin
            end_flag_q <= 1'b0;
        end else if (end_set) begin
            end_flag_q <= 1'b1;
        end
    end

    // Analog drive requests
    always_comb begin
        drive_o                        = '0;
        drive_o.charge_enable          = state_q == ST_PRE || state_q == ST_FAST || state_q == ST_CV;
        // RULE1 precharge current request
        drive_o.precharge_current_sel  = state_q == ST_PRE;
        // RULE4 full constant current
        drive_o.fast_charge_current    = state_q == ST_FAST;
        // RULE5 voltage regulation
        drive_o.cv_mode                = state_q == ST_CV;
        drive_o.regulation_voltage_sel = ctrl_q[CTRL_VREG_BIT];
        drive_o.use_default_threshold  = use_default;
    end

    // RULE15 status encoding; ON means the open-drain pin pulls low
    assign st_on_a = state_q == ST_PRE || state_q == ST_FAST || state_q == ST_CV
                     || state_q == ST_FAULT;
    assign st_on_b = state_q == ST_DONE || state_q == ST_FAULT || end_flag_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_out_a_oe <= 1'b0;
            status_out_b_oe <= 1'b0;
        end else begin
            status_out_a_oe <= st_on_a;
            status_out_b_oe <= st_on_b;
        end
    end
    assign status_out_a_o = 1'b0;
    assign status_out_b_o = 1'b0;

    // APB decode; zero wait states
    assign pready   = 1'b1;
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign addr_ok  = paddr == OFS_CTRL || paddr == OFS_TMAX || paddr == OFS_PRESCALE
                      || paddr == OFS_STATUS || paddr == OFS_INT_STAT || paddr == OFS_INT_MASK;
    assign pslverr  = psel && penable && !addr_ok;

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q     <= CTRL_RST;
            tmax_q     <= TW'(TMAX_DEF);
            prescale_q <= PW'(PRESCALE_DEF);
            int_mask_q <= IRQ_RST;
        end else if (wr_en) begin
            case (paddr)
                OFS_CTRL:     ctrl_q     <= pwdata[1:0];
                OFS_TMAX:     tmax_q     <= pwdata[TW-1:0];
                OFS_PRESCALE: prescale_q <= pwdata[PW-1:0];
                OFS_INT_MASK: int_mask_q <= pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Sticky events; a set in the clearing cycle wins
    assign events[IRQ_FAST] = state_d == ST_FAST && state_q != ST_FAST;
    assign events[IRQ_DONE] = state_d == ST_DONE && state_q != ST_DONE;
    assign events[IRQ_TMO]  = state_d == ST_FAULT && state_q != ST_FAULT;
    assign events[IRQ_END]  = end_set;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_q <= IRQ_RST;
        end else if (wr_en && paddr == OFS_INT_STAT) begin
            int_stat_q <= (int_stat_q & ~pwdata[IRQ_W-1:0]) | events;
        end else begin
            int_stat_q <= int_stat_q | events;
        end
    end
    assign irq = |(int_stat_q & int_mask_q);

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (paddr)
                OFS_CTRL:     prdata <= {30'h0000_0000, ctrl_q};
                OFS_TMAX:     prdata <= {8'h00, tmax_q};
                OFS_PRESCALE: prdata <= {16'h0000, prescale_q};
                OFS_STATUS:   prdata <= {25'h000_0000, use_default, status_out_b_oe,
                                         status_out_a_oe, end_flag_q, state_q};
                OFS_INT_STAT: prdata <= {28'h000_0000, int_stat_q};
                OFS_INT_MASK: prdata <= {28'h000_0000, int_mask_q};
                default:      prdata <= 32'h0000_0000;
            endcase
        end
    end

    AST_PRE_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_IDLE && enable && vbat_low |=> state_q == ST_PRE) else $error("No precharge"); // RULE1
    AST_SKIP_PRE: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_IDLE && enable && !vbat_low |=> state_q == ST_FAST) else $error("No skip"); // RULE3
    AST_PRE_TO_FAST: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_PRE && enable && !vbat_low |=> drive_o.fast_charge_current) else $error("No fast"); // RULE4
    AST_CV_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_FAST && enable && cmp.near_regulation_voltage && !chg_exp
        |=> state_q == ST_CV) else $error("No regulation phase"); // RULE5
    AST_RECHARGE: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_DONE && enable && cmp.below_recharge_voltage_threshold
        |=> drive_o.charge_enable) else $error("No recharge"); // RULE6
    AST_PRE_TMO: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_PRE && enable && vbat_low && pre_exp && !rst_edge
        |=> state_q == ST_FAULT ##1 !drive_o.charge_enable) else $error("No pre timeout"); // RULE9
    AST_CHG_TMO: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == ST_FAST || state_q == ST_CV) && enable && chg_exp && !rst_edge
        |=> state_q == ST_FAULT) else $error("No charge timeout"); // RULE8
    AST_TERM: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_CV && enable && deg_exp && cmp.precharge_program_pin_hi && !chg_exp
        |=> state_q == ST_DONE ##1 status_out_b_oe && !status_out_a_oe) else $error("No end"); // RULE11
    AST_NOTERM: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_CV && enable && deg_exp && !cmp.precharge_program_pin_hi && !chg_exp
        |=> state_q == ST_CV && end_flag_q) else $error("Bad no-term end"); // RULE12
    AST_FAULT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_FAULT && enable && !rst_edge |=> state_q == ST_FAULT) else $error("Fault lost"); // RULE17
    AST_FAULT_PINS: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_FAULT |=> status_out_a_oe && status_out_b_oe) else $error("Fault pins"); // RULE15
    AST_EDGE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        rst_edge && (state_q == ST_PRE || state_q == ST_FAST) && enable
        |=> !chg_exp && !pre_exp) else $error("Timer not reset"); // RULE14
    AST_DEF_THR: assert property (@(posedge pclk) disable iff (!presetn)
        !cmp.precharge_program_pin_hi |-> drive_o.use_default_threshold) else $error("Default thr"); // RULE13

endmodule : lcs_charge_seq

// ### verification/lcs_battery_model.sv
// Cell and adapter model: cell voltage and pin level to comparator levels.
// Assumes the bench sets the cell state; levels follow the charger drive.
`timescale 1ns/1ps
module lcs_battery_model
    import lcs_pkg::*;
#(
    parameter int PROG_MV  = 3000,
    parameter int FLOAT_MV = 1230
) (
    input  wire lcs_drive_s drive,
    input  wire logic       pin_open,
    input  var  int         vbat_mv,
    input  var  int         vpin_mv,
    input  wire logic       low_cur,
    output lcs_cmp_s        cmp
);
    int vreg;
    int vp;

    assign vreg = drive.regulation_voltage_sel ? 4200 : 4100;
    // Open pin floats up inside the charger
    assign vp = pin_open ? FLOAT_MV : vpin_mv;

    // Comparator levels, recomputed on every cell change
    always_comb begin
        cmp.below_precharge_voltage_threshold = vbat_mv < PROG_MV;
        cmp.below_default_precharge_threshold = vbat_mv < 2800;
        cmp.precharge_program_pin_floating = pin_open;
        cmp.precharge_program_pin_hi = vp > 800;
        cmp.precharge_program_pin_mid = vp > 500;
        cmp.near_regulation_voltage = vbat_mv >= vreg - 50;
        cmp.below_recharge_voltage_threshold = vbat_mv < vreg - 150;
        // Current tapers only while voltage is regulated
        cmp.at_end_of_charge_current_threshold = low_cur && drive.cv_mode;
    end
endmodule : lcs_battery_model

// ### verification/lcs_charge_seq_tb.sv
// Self-checking bench for the charge sequencer over APB and comparator levels.
// Assumes a tick every clock and a short charge time to keep runs brief.
`timescale 1ns/1ps
module lcs_charge_seq_tb import lcs_pkg::*;;
    localparam int TMAX = 440;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    lcs_cmp_s    cmp;
    lcs_drive_s  drv;
    logic        a_oe;
    logic        b_oe;
    logic        a_o;
    logic        b_o;
    logic        irq;
    logic        pin_open = 1'b1;
    int          vbat = 2500;
    int          vpin = 1000;
    logic        low_cur = 1'b0;
    int          errors = 0;
    int          checks_done = 0;
    logic [31:0] rd;
    logic        err_q;

    // Clock, 100 ns period
    always #50 pclk = ~pclk;

    lcs_charge_seq #(.PRESCALE_DEF(1), .TMAX_DEF(TMAX)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmp_i(cmp), .drive_o(drv),
        .status_out_a_o(a_o), .status_out_a_oe(a_oe), .status_out_b_o(b_o),
        .status_out_b_oe(b_oe), .irq(irq));
    lcs_battery_model bat_u (.drive(drv), .pin_open(pin_open), .vbat_mv(vbat),
        .vpin_mv(vpin), .low_cur(low_cur), .cmp(cmp));

    // One APB transfer; idle cycle first so strobes never repeat in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // No wait count assumed; the watchdog ends a hung transfer
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Poll the state field under a bounded count
    task automatic wait_st(input logic [2:0] s, input int polls);
        for (int i = 0; i < polls; i++) begin
            apb(1'b0, OFS_STATUS, 32'h0000_0000);
            if (rd[2:0] === s) break;
        end
        chk("state", {29'h0, s}, {29'h0, rd[2:0]});
    endtask : wait_st

    // Pins lag the state by one cycle
    task automatic pins(input logic a, input logic b);
        @(posedge pclk);
        chk("pin_a", {31'h0, a}, {31'h0, a_oe});
        chk("pin_b", {31'h0, b}, {31'h0, b_oe});
        chk("pin_lvl", 32'h0000_0000, {30'h0, a_o, b_o});
    endtask : pins

    task automatic t_regs();
        apb(1'b0, OFS_TMAX, 32'h0000_0000);
        chk("tmax", TMAX, rd);
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk("unmapped", 32'h0000_0001, {31'h0, err_q});
        apb(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("status", 32'h0000_0040, rd);
    endtask : t_regs

    task automatic t_cycle();
        pin_open <= 1'b0;
        apb(1'b1, OFS_INT_MASK, 32'h0000_0001);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        wait_st(ST_PRE, 10);
        chk("low_cur", 1, drv.precharge_current_sel);
        pins(1'b1, 1'b0);
        vbat <= 3200;
        wait_st(ST_FAST, 10);
        chk("full_cur", 1, drv.fast_charge_current);
        chk("irq_on", 1, irq);
        apb(1'b1, OFS_INT_STAT, 32'h0000_0001);
        apb(1'b1, OFS_INT_MASK, 32'h0000_0002);
        chk("irq_clr", 0, irq);
        vbat <= 4060;
        wait_st(ST_CV, 10);
        chk("cv", 1, drv.cv_mode);
        low_cur <= 1'b1;
        wait_st(ST_DONE, 10);
        pins(1'b0, 1'b1);
        chk("irq_done", 1, irq);
        apb(1'b1, OFS_INT_STAT, 32'h0000_000F);
        low_cur <= 1'b0;
        vbat <= 3940;
        wait_st(ST_FAST, 10);
        repeat (200) @(posedge pclk);
        wait_st(ST_FAST, 1);
        // Falling edge mid fast charge restarts the timer, so no fault at 440
        vpin <= 300;
        repeat (300) @(posedge pclk);
        wait_st(ST_FAST, 1);
        wait_st(ST_FAULT, 200);
        pins(1'b1, 1'b1);
        chk("irq_mask", 0, irq);
        repeat (50) @(posedge pclk);
        wait_st(ST_FAULT, 1);
        chk("chg_off", 0, drv.charge_enable);
        vpin <= 1000;
        repeat (4) @(posedge pclk);
        vpin <= 300;
        wait_st(ST_FAST, 10);
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
    endtask : t_cycle

    task automatic t_pretmo();
        pin_open <= 1'b1;
        vbat <= 2500;
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        wait_st(ST_PRE, 10);
        chk("dflt", 1, drv.use_default_threshold);
        repeat (40) @(posedge pclk);
        wait_st(ST_PRE, 1);
        wait_st(ST_FAULT, 20);
        chk("pre_off", 0, drv.charge_enable);
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        wait_st(ST_IDLE, 5);
    endtask : t_pretmo

    task automatic t_noterm();
        pin_open <= 1'b0;
        vpin <= 600;
        vbat <= 2900;
        apb(1'b1, OFS_CTRL, 32'h0000_0003);
        wait_st(ST_FAST, 10);
        chk("vsel", 1, drv.regulation_voltage_sel);
        vbat <= 4160;
        wait_st(ST_CV, 10);
        low_cur <= 1'b1;
        repeat (20) @(posedge pclk);
        wait_st(ST_CV, 1);
        chk("end_flag", 1, rd[STS_END_BIT]);
        pins(1'b1, 1'b1);
        wait_st(ST_FAULT, 200);
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
    endtask : t_noterm

    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    // Watchdog well beyond the fewer than two thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        $display("watchdog expired");
        complete_run();
    end

    // Reset for eight cycles, then the scenarios in turn
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_cycle();
        t_pretmo();
        t_noterm();
        complete_run();
    end
endmodule : lcs_charge_seq_tb
